// ### shared/sps_map.svh
// constants of the serial port select and two-wire target
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH

// strap codes as {high strap, low strap}
`define SPS_SEL_SPI      2'h0
`define SPS_SEL_LO_ONLY  2'h1
`define SPS_SEL_HI_ONLY  2'h2
`define SPS_SEL_BOTH     2'h3

// target address: fixed upper five bits, low two from straps
`define SPS_ADDR_UPPER   5'h18
`define SPS_LOW2_LO_ONLY 2'h0
`define SPS_LOW2_HI_ONLY 2'h1
`define SPS_LOW2_BOTH    2'h2

// register space
`define SPS_REG_LAST     16'h0234
`define SPS_PTR_STEP     16'h0001
`define SPS_PTR_RESET    16'h0000
`define SPS_MEM_AW       10
`define SPS_MEM_DEPTH    565

// byte framing
`define SPS_BIT_LAST     3'h7
`define SPS_BIT_STEP     3'h1
`define SPS_BIT_FIRST    3'h0
`define SPS_WIDX_HI      2'h0
`define SPS_WIDX_LO      2'h1
`define SPS_WIDX_DATA    2'h2
`define SPS_ZERO_BYTE    8'h00

`endif

// ### shared/sps_pkg.sv
// types of the serial port select and two-wire target
`default_nettype none
package sps_pkg;

  typedef enum logic [2:0] {
    SPS_IDLE,
    SPS_RX_BYTE,
    SPS_ACK_OUT,
    SPS_TX_BYTE,
    SPS_ACK_IN
  } sps_link_state_t;

  typedef enum logic {
    SPS_OP_READ,
    SPS_OP_WRITE
  } sps_op_t;

endpackage : sps_pkg
`default_nettype wire

// ### hw/sps_reg_mem.sv
// byte-wide register store with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.svh"

module sps_reg_mem (
  input  wire logic                     clk,
  input  wire logic                     wr_en,
  input  wire logic [`SPS_MEM_AW-1:0]   wr_addr,
  input  wire logic [7:0]               wr_data,
  input  wire logic [`SPS_MEM_AW-1:0]   rd_addr,
  output logic      [7:0]               rd_data
);

  logic [7:0] mem [0:`SPS_MEM_DEPTH-1];

  // power-up contents are zero; no reset port keeps it a plain ram
  initial begin
    for (int i = 0; i < `SPS_MEM_DEPTH; i++) begin
      mem[i] = `SPS_ZERO_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : sps_reg_mem
`default_nettype wire

// ### hw/sps_i2c_target.sv
// two-wire register target with strap-selected port mode
// How it works
// - straps sampled after reset pick port mode
// - target address from fixed bits plus straps
// - runs at standard and fast bus rates
// - clock line is input only, never driven
// - register address is two bytes wide
// - data changes only while clock is low
// - start condition begins a new transfer
// - stop condition returns target to idle
// - eight bits, msb first, then ack slot
// - acknowledge is data held low, ninth pulse
// - not-acknowledge is data left high
// - acknowledge only own address, else stay idle
// - write: two pointer bytes, then data bytes
// - read: data bytes from current pointer
// - pointer increments per data byte, unlimited for reads, stops after last register write
// - master nack ends read, data released
// - repeated start or stop anytime discards byte
// - nack data byte after last register write
// - reads past last register return zero
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.svh"

module sps_i2c_target (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        link_clk,
  input  wire logic        port_select_high_strap,
  input  wire logic        port_select_low_strap,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             i2c_enable,
  output logic             spi_enable,
  output logic             reg_wr_strobe,
  output logic [15:0]      reg_wr_addr,
  output logic [7:0]       reg_wr_data
);
  import sps_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // link domain reset and input synchronisers
  logic        lrst_s1_reg;
  logic        lrst_reg;
  logic        scl_s1_reg;
  logic        scl_s2_reg;
  logic        scl_s3_reg;
  logic        sda_s1_reg;
  logic        sda_s2_reg;
  logic        sda_s3_reg;
  logic [1:0]  strap_s1_reg;
  logic [1:0]  strap_s2_reg;
  always_ff @(posedge link_clk) begin
    lrst_s1_reg <= reset;
    lrst_reg    <= lrst_s1_reg;
  end
  // ~50 link samples per bit even at fast rate, so no glitch filter
  always_ff @(posedge link_clk) begin
    scl_s1_reg <= scl_in;
    scl_s2_reg <= scl_s1_reg;
    scl_s3_reg <= scl_s2_reg;
    sda_s1_reg <= sda_in;
    sda_s2_reg <= sda_s1_reg;
    sda_s3_reg <= sda_s2_reg;
    strap_s1_reg <= {port_select_high_strap, port_select_low_strap};
    strap_s2_reg <= strap_s1_reg;
  end
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise   = scl_s2_reg & ~scl_s3_reg;
  assign scl_fall   = ~scl_s2_reg & scl_s3_reg;
  assign start_seen = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  assign stop_seen  = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

  ////////////////////////////////////////////////////////////////////
  // strap capture, once after reset release
  logic        captured_reg;
  logic        i2c_on_reg;
  logic        spi_on_reg;
  logic [1:0]  low2_reg;
  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      captured_reg <= 1'b0;
      i2c_on_reg   <= 1'b0;
      spi_on_reg   <= 1'b0;
      low2_reg     <= `SPS_LOW2_LO_ONLY;
    end else if (!captured_reg) begin
      captured_reg <= 1'b1;
      i2c_on_reg   <= (strap_s2_reg != `SPS_SEL_SPI);
      spi_on_reg   <= (strap_s2_reg == `SPS_SEL_SPI);
      unique case (strap_s2_reg)
        `SPS_SEL_HI_ONLY: low2_reg <= `SPS_LOW2_HI_ONLY;
        `SPS_SEL_BOTH:    low2_reg <= `SPS_LOW2_BOTH;
        default:          low2_reg <= `SPS_LOW2_LO_ONLY;
      endcase
    end
  end

  assign i2c_enable = i2c_on_reg;
  assign spi_enable = spi_on_reg;

  ////////////////////////////////////////////////////////////////////
  // byte engine
  sps_link_state_t state_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic        sda_oe_n_reg;
  logic        ack_phase_reg;
  logic        nack_reg;
  logic        addr_phase_reg;
  logic        rw_reg;
  logic [1:0]  widx_reg;
  logic        wr_end_reg;
  logic [15:0] ptr_reg;
  logic [7:0]  rd_byte_reg;
  logic [7:0]  rx_byte;
  logic        rx_done;
  logic        addr_hit;
  logic        rd_go;
  logic        wr_go;
  assign rx_byte  = {shift_reg[6:0], sda_s2_reg};
  assign rx_done  = (state_reg == SPS_RX_BYTE) & scl_rise & (bit_cnt_reg == `SPS_BIT_LAST);
  assign addr_hit = rx_done & addr_phase_reg & i2c_on_reg
                    & (rx_byte[7:1] == {`SPS_ADDR_UPPER, low2_reg});
  assign rd_go    = (addr_hit & rx_byte[0])
                    | ((state_reg == SPS_ACK_IN) & scl_rise & ~sda_s2_reg & ~ack_phase_reg);
  assign wr_go    = rx_done & ~addr_phase_reg & (widx_reg == `SPS_WIDX_DATA) & ~wr_end_reg;

  // clock line never driven: no output port for it
  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      state_reg      <= SPS_IDLE;
      bit_cnt_reg    <= `SPS_BIT_FIRST;
      shift_reg      <= `SPS_ZERO_BYTE;
      sda_oe_n_reg   <= 1'b1;
      ack_phase_reg  <= 1'b0;
      nack_reg       <= 1'b0;
      addr_phase_reg <= 1'b1;
      rw_reg         <= 1'b0;
      widx_reg       <= `SPS_WIDX_HI;
      wr_end_reg     <= 1'b0;
    end else if (stop_seen) begin
      state_reg    <= SPS_IDLE;
      sda_oe_n_reg <= 1'b1;
    end else if (start_seen) begin
      state_reg      <= SPS_RX_BYTE;
      bit_cnt_reg    <= `SPS_BIT_FIRST;
      sda_oe_n_reg   <= 1'b1;
      ack_phase_reg  <= 1'b0;
      addr_phase_reg <= 1'b1;
      widx_reg       <= `SPS_WIDX_HI;
      wr_end_reg     <= 1'b0;
    end else begin
      unique case (state_reg)
        SPS_IDLE: begin
          sda_oe_n_reg <= 1'b1;
        end
        SPS_RX_BYTE: begin
          if (scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + `SPS_BIT_STEP;
            if (bit_cnt_reg == `SPS_BIT_LAST) begin
              if (addr_phase_reg) begin
                // a foreign address leaves the bus alone until next start
                state_reg      <= addr_hit ? SPS_ACK_OUT : SPS_IDLE;
                rw_reg         <= rx_byte[0];
                nack_reg       <= 1'b0;
                addr_phase_reg <= 1'b0;
              end else begin
                state_reg <= SPS_ACK_OUT;
                nack_reg  <= (widx_reg == `SPS_WIDX_DATA) & wr_end_reg;
                if (widx_reg != `SPS_WIDX_DATA) begin
                  widx_reg <= widx_reg + `SPS_WIDX_LO;
                end
                if (wr_go && ptr_reg == `SPS_REG_LAST) begin
                  wr_end_reg <= 1'b1;
                end
              end
            end
          end
        end
        SPS_ACK_OUT: begin
          if (scl_fall) begin
            if (!ack_phase_reg) begin
              sda_oe_n_reg  <= nack_reg;
              ack_phase_reg <= 1'b1;
            end else begin
              ack_phase_reg <= 1'b0;
              bit_cnt_reg   <= `SPS_BIT_FIRST;
              if (nack_reg) begin
                state_reg    <= SPS_IDLE;
                sda_oe_n_reg <= 1'b1;
              end else if (rw_reg) begin
                state_reg    <= SPS_TX_BYTE;
                shift_reg    <= rd_byte_reg;
                sda_oe_n_reg <= rd_byte_reg[7];
              end else begin
                state_reg    <= SPS_RX_BYTE;
                sda_oe_n_reg <= 1'b1;
              end
            end
          end
        end
        SPS_TX_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `SPS_BIT_LAST) begin
              state_reg     <= SPS_ACK_IN;
              sda_oe_n_reg  <= 1'b1;
              ack_phase_reg <= 1'b0;
            end else begin
              bit_cnt_reg  <= bit_cnt_reg + `SPS_BIT_STEP;
              sda_oe_n_reg <= shift_reg[6];
              shift_reg    <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        SPS_ACK_IN: begin
          if (scl_rise && !ack_phase_reg) begin
            if (sda_s2_reg) begin
              state_reg <= SPS_IDLE;
            end else begin
              ack_phase_reg <= 1'b1;
            end
          end else if (scl_fall && ack_phase_reg) begin
            state_reg     <= SPS_TX_BYTE;
            ack_phase_reg <= 1'b0;
            bit_cnt_reg   <= `SPS_BIT_FIRST;
            shift_reg     <= rd_byte_reg;
            sda_oe_n_reg  <= rd_byte_reg[7];
          end
        end
      endcase
    end
  end

  // open drain: the data level is always low, only the enable moves
  always_ff @(posedge link_clk) begin
    sda_out  <= 1'b0;
    sda_oe_n <= sda_oe_n_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // pointer and requests towards the register store
  logic        req_tgl_reg;
  sps_op_t     op_reg;
  logic [15:0] xaddr_reg;
  logic [7:0]  xdata_reg;
  // pointer has no clear on start or stop, so reads resume where left
  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      ptr_reg     <= `SPS_PTR_RESET;
      req_tgl_reg <= 1'b0;
      op_reg      <= SPS_OP_READ;
      xaddr_reg   <= `SPS_PTR_RESET;
      xdata_reg   <= `SPS_ZERO_BYTE;
    end else if (rd_go) begin
      op_reg      <= SPS_OP_READ;
      xaddr_reg   <= ptr_reg;
      req_tgl_reg <= ~req_tgl_reg;
      ptr_reg     <= ptr_reg + `SPS_PTR_STEP;
    end else if (wr_go) begin
      op_reg      <= SPS_OP_WRITE;
      xaddr_reg   <= ptr_reg;
      xdata_reg   <= rx_byte;
      req_tgl_reg <= ~req_tgl_reg;
      ptr_reg     <= ptr_reg + `SPS_PTR_STEP;
    end else if (rx_done && !addr_phase_reg && widx_reg == `SPS_WIDX_HI) begin
      ptr_reg[15:8] <= rx_byte;
    end else if (rx_done && !addr_phase_reg && widx_reg == `SPS_WIDX_LO) begin
      ptr_reg[7:0] <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read answers back into the link domain
  logic        ack_s1_reg;
  logic        ack_s2_reg;
  logic        ack_s3_reg;
  logic        ack_tgl_reg;
  logic [7:0]  resp_data_reg;
  always_ff @(posedge link_clk) begin
    ack_s1_reg <= ack_tgl_reg;
    ack_s2_reg <= ack_s1_reg;
    ack_s3_reg <= ack_s2_reg;
  end
  // answer word is held still by the core until the next request
  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      rd_byte_reg <= `SPS_ZERO_BYTE;
    end else if (ack_s2_reg != ack_s3_reg) begin
      rd_byte_reg <= resp_data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // core domain: request detect and register store access
  logic        req_s1_reg;
  logic        req_s2_reg;
  logic        req_s3_reg;
  logic        rd_pend_reg;
  logic        req_seen;
  logic        in_range;
  logic        mem_we;
  logic [7:0]  mem_rd_data;
  always_ff @(posedge core_clk) begin
    req_s1_reg <= req_tgl_reg;
    req_s2_reg <= req_s1_reg;
    req_s3_reg <= req_s2_reg;
  end
  assign req_seen = req_s2_reg ^ req_s3_reg;
  assign in_range = (xaddr_reg <= `SPS_REG_LAST);
  assign mem_we   = req_seen & (op_reg == SPS_OP_WRITE) & in_range;
  sps_reg_mem u_mem (
    .clk     (core_clk),
    .wr_en   (mem_we),
    .wr_addr (xaddr_reg[`SPS_MEM_AW-1:0]),
    .wr_data (xdata_reg),
    .rd_addr (xaddr_reg[`SPS_MEM_AW-1:0]),
    .rd_data (mem_rd_data)
  );
  // one spare cycle lets the store register its read data
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_pend_reg   <= 1'b0;
      ack_tgl_reg   <= 1'b0;
      resp_data_reg <= `SPS_ZERO_BYTE;
    end else begin
      rd_pend_reg <= req_seen & (op_reg == SPS_OP_READ);
      if (rd_pend_reg) begin
        resp_data_reg <= in_range ? mem_rd_data : `SPS_ZERO_BYTE;
        ack_tgl_reg   <= ~ack_tgl_reg;
      end else if (req_seen && op_reg == SPS_OP_WRITE) begin
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end

  // written bytes are also shown to the device logic
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_wr_strobe <= 1'b0;
      reg_wr_addr   <= `SPS_PTR_RESET;
      reg_wr_data   <= `SPS_ZERO_BYTE;
    end else begin
      reg_wr_strobe <= mem_we;
      if (mem_we) begin
        reg_wr_addr <= xaddr_reg;
        reg_wr_data <= xdata_reg;
      end
    end
  end

endmodule : sps_i2c_target
`default_nettype wire

// ### dv/sps_i2c_target_assertions.sv
// port checks of the two-wire target
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.svh"
module sps_i2c_target_assertions (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        link_clk,
  input wire logic        scl_in,
  input wire logic        sda_oe_n,
  input wire logic        i2c_enable,
  input wire logic        spi_enable,
  input wire logic        reg_wr_strobe,
  input wire logic [15:0] reg_wr_addr,
  input wire logic [7:0]  reg_wr_data
);
  logic [3:0] settle_cnt_reg;
  // straps need a few link edges to land after reset
  always_ff @(posedge link_clk) begin
    if (reset) begin
      settle_cnt_reg <= 4'h0;
    end else if (settle_cnt_reg != 4'hF) begin
      settle_cnt_reg <= settle_cnt_reg + 4'h1;
    end
  end
  a_mode_onehot: assert property (@(posedge link_clk) disable iff (reset)
    settle_cnt_reg == 4'hF |-> i2c_enable != spi_enable) else $error("port mode not exclusive");
  a_mode_held: assert property (@(posedge link_clk) disable iff (reset)
    settle_cnt_reg == 4'hF |-> $stable(i2c_enable) && $stable(spi_enable)) else $error("port mode changed");
  a_spi_silent: assert property (@(posedge link_clk) disable iff (reset)
    spi_enable |-> sda_oe_n) else $error("data driven in four-wire mode");
  a_drive_scl_low: assert property (@(posedge link_clk) disable iff (reset)
    $fell(sda_oe_n) |-> !scl_in) else $error("data driven while clock high");
  a_drive_stands: assert property (@(posedge link_clk) disable iff (reset)
    $fell(sda_oe_n) |-> !sda_oe_n [*8]) else $error("driven bit too short");
  a_strobe_once: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr_strobe |=> !reg_wr_strobe) else $error("write strobe too long");
  a_wr_in_range: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr_strobe |-> reg_wr_addr <= `SPS_REG_LAST) else $error("write past last register");
  a_wr_held: assert property (@(posedge core_clk) disable iff (reset)
    !reg_wr_strobe |-> $stable(reg_wr_addr) && $stable(reg_wr_data)) else $error("write port moved");
endmodule : sps_i2c_target_assertions
bind sps_i2c_target sps_i2c_target_assertions u_chk (.core_clk(core_clk), .reset(reset),
  .link_clk(link_clk), .scl_in(scl_in), .sda_oe_n(sda_oe_n), .i2c_enable(i2c_enable),
  .spi_enable(spi_enable), .reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr),
  .reg_wr_data(reg_wr_data));
`default_nettype wire

// ### dv/sps_bus_master.sv
// two-wire bus controller model
`timescale 1ns/100ps
`default_nettype none
module sps_bus_master (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  int q = 300;
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  // data moves mid-low only
  task automatic bit_x(input logic b, output logic r);
    #q sda_m = b;
    #q scl = 1'b1;
    #q r = sda;
    #q scl = 1'b0;
  endtask : bit_x
  // clock stays high between frames
  task automatic start();
    #q sda_m = 1'b1;
    #q scl = 1'b1;
    #q sda_m = 1'b0;
    #q scl = 1'b0;
  endtask : start
  task automatic stop();
    #q sda_m = 1'b0;
    #q scl = 1'b1;
    #q sda_m = 1'b1;
    #q;
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : send
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask : recv
endmodule : sps_bus_master
`default_nettype wire

// ### dv/sps_i2c_target_tb.sv
// bench of the two-wire register target
`timescale 1ns/100ps
`default_nettype none
module sps_i2c_target_tb;
  typedef struct packed {logic hi; logic lo; logic i2c; logic spi; logic [6:0] addr;} sps_row_t;
  localparam logic [7:0] WR = 8'hC4;
  localparam logic [7:0] RD = 8'hC5;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hi_s = 1'b0;
  logic        lo_s = 1'b0;
  logic        scl, sda_m, sda_w, sda_out, sda_oe_n, i2c_en, spi_en, wr_stb;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic [23:0] wr_log [$];
  int          error_cnt = 0;
  int          cmp_count = 0;
  sps_row_t    rows [4] = '{'{1'b0, 1'b0, 1'b0, 1'b1, 7'h60}, '{1'b0, 1'b1, 1'b1, 1'b0, 7'h60},
                            '{1'b1, 1'b0, 1'b1, 1'b0, 7'h61}, '{1'b1, 1'b1, 1'b1, 1'b0, 7'h62}};
  always #5 core_clk = ~core_clk;
  always #24 link_clk = ~link_clk;
  // wired-and with pull-up
  assign sda_w = sda_m & (sda_oe_n ? 1'b1 : sda_out);
  sps_bus_master m (.scl(scl), .sda_m(sda_m), .sda(sda_w));
  sps_i2c_target dut (.core_clk(core_clk), .reset(reset), .link_clk(link_clk), .port_select_high_strap(hi_s),
    .port_select_low_strap(lo_s), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .i2c_enable(i2c_en), .spi_enable(spi_en), .reg_wr_strobe(wr_stb), .reg_wr_addr(wr_addr),
    .reg_wr_data(wr_data));
  always @(posedge core_clk) if (wr_stb === 1'b1) wr_log.push_back({wr_addr, wr_data});
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({23'h0, got}, {23'h0, exp});
  endtask : chk_bit
  task automatic chk_log(input logic [23:0] exp);
    if (wr_log.size() == 0) begin
      chk_val(24'hFFFFFF, exp);
    end else begin
      chk_val(wr_log.pop_front(), exp);
    end
  endtask : chk_log
  task automatic sb(input logic [7:0] d, input logic exp);
    logic a;
    m.send(d, a);
    chk_bit(a, exp);
  endtask : sb
  task automatic rb(input logic mack, input logic [7:0] exp);
    logic [7:0] d;
    m.recv(mack, d);
    chk_val({16'h0, d}, {16'h0, exp});
  endtask : rb
  // reset held long enough for the link domain too
  task automatic do_reset(input logic hi, input logic lo);
    @(posedge core_clk);
    hi_s  <= hi;
    lo_s  <= lo;
    reset <= 1'b1;
    repeat (24) @(posedge core_clk);
    #1 chk_bit(sda_oe_n, 1'b1);
    chk_bit(wr_stb, 1'b0);
    chk_bit(sda_out, 1'b0);
    chk_val({wr_addr, wr_data}, 24'h0);
    @(posedge core_clk);
    reset <= 1'b0;
    repeat (80) @(posedge core_clk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////
  initial begin
    #950us;
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end
  initial begin
    sps_row_t r;
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      do_reset(r.hi, r.lo);
      chk_bit(i2c_en, r.i2c);
      chk_bit(spi_en, r.spi);
      m.start();
      sb({r.addr, 1'b0}, r.i2c);
      m.stop();
      m.start();
      sb({r.addr ^ 7'h01, 1'b0}, 1'b0);
      m.stop();
    end
    // write two bytes, pointer steps
    m.start();
    sb(WR, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h10, 1'b1);
    sb(8'hA5, 1'b1);
    sb(8'h3C, 1'b1);
    m.stop();
    chk_log(24'h0010A5);
    chk_log(24'h00113C);
    // pointer then repeated start read, nack ends it
    m.start();
    sb(WR, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h10, 1'b1);
    m.start();
    sb(RD, 1'b1);
    rb(1'b1, 8'hA5);
    rb(1'b0, 8'h3C);
    #250 chk_bit(sda_oe_n, 1'b1);
    // one more clock pulse: a released line must stay high
    m.bit_x(1'b1, r.lo);
    chk_bit(r.lo, 1'b1);
    m.stop();
    // pointer only, then a bare read later
    m.start();
    sb(WR, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h10, 1'b1);
    m.stop();
    m.start();
    sb(RD, 1'b1);
    rb(1'b0, 8'hA5);
    m.stop();
    // top of the register space
    m.start();
    sb(WR, 1'b1);
    sb(8'h02, 1'b1);
    sb(8'h33, 1'b1);
    sb(8'h11, 1'b1);
    sb(8'h22, 1'b1);
    sb(8'h99, 1'b0);
    m.stop();
    chk_log(24'h023311);
    chk_log(24'h023422);
    m.start();
    sb(WR, 1'b1);
    sb(8'h02, 1'b1);
    sb(8'h34, 1'b1);
    m.start();
    sb(RD, 1'b1);
    rb(1'b1, 8'h22);
    rb(1'b1, 8'h00);
    rb(1'b0, 8'h00);
    m.stop();
    // broken byte, then restart at fast-mode rate
    m.q = 625;
    m.start();
    sb(WR, 1'b1);
    sb(8'h00, 1'b1);
    for (int i = 0; i < 3; i++) m.bit_x(1'b1, r.hi);
    m.start();
    sb(WR, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h20, 1'b1);
    sb(8'h5A, 1'b1);
    m.stop();
    chk_log(24'h00205A);
    chk_val(24'(wr_log.size()), 24'h0);
    // pointer back to 0x0020, then read it at standard rate
    m.start();
    sb(WR, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h20, 1'b1);
    m.stop();
    m.q = 2500;
    m.start();
    sb(RD, 1'b1);
    rb(1'b0, 8'h5A);
    m.stop();
    // late reset must clear the write port again
    do_reset(1'b1, 1'b1);
    chk_bit(i2c_en, 1'b1);
    stop_test();
  end
endmodule : sps_i2c_target_tb
`default_nettype wire
